// [dv/bit_error_rate_checker_tb.sv]
// Self-checking bench for the bit error rate checker
`timescale 1ns/1ps
`default_nettype none
module bit_error_rate_checker_tb;
   import ber_check_pkg::*;
   localparam logic [31:0] ALL = 32'hffffffff;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, en = 1'b1, fall = 1'b0, err = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, seed = 32'h64d5;
   logic        ack, fclk, fdat, fden;
   logic [31:0] exp_q[$], msk_q[$];
   int          mismatches = 0, tests_run = 0;
   always #20 clk_i = ~clk_i;
   bit_error_rate_checker u_bit_error_rate_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .fb_clk_i(fclk), .fb_data_i(fdat), .fb_den_i(fden));
   prbs_source u_prbs_source (.en_i(en), .fall_i(fall), .err_i(err), .fb_clk_o(fclk), .fb_data_o(fdat),
      .fb_den_o(fden));
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      mismatches += exp_q.size();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // One classic cycle; the ack wait is bounded so a dead slave ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
      do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin mismatches++; wrap_up(); end
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = ALL);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask
   // Scoreboard: each read answer is matched against the oldest note
   always @(posedge clk_i) if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      check(rdat & msk_q.pop_front(), exp_q.pop_front());
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(OFS_CONFIG, 32'h0, 32'hf);
      rd(OFS_CHK_LIMIT, CHK_LIMIT_RST);
      rd(OFS_ERR_LIMIT, ERR_LIMIT_RST);
      rd(8'h20, 32'h0);
      seed = lfsr_next(seed);
      bus(1'b1, OFS_CHK_LIMIT, seed);
      rd(OFS_CHK_LIMIT, seed);
      $display("Test defaults done");
      // Single shot on the falling edge: nothing runs until the trigger
      fall <= 1'b1;
      bus(1'b1, OFS_CONFIG, 32'h3);
      bus(1'b1, OFS_CHK_LIMIT, 32'd200);
      bus(1'b1, OFS_ERR_LIMIT, 32'd1000);
      repeat (300) @(posedge clk_i);
      rd(OFS_RES_CHECKED, 32'h0);
      rd(OFS_RES_STATUS, 32'h6, 32'hf);
      bus(1'b1, OFS_CTRL, 32'h2);
      repeat (400) @(posedge clk_i);
      rd(OFS_RES_CHECKED, 32'd200);
      rd(OFS_RES_ERRORS, 32'h0);
      rd(OFS_RES_STATUS, 32'hf, 32'hf);
      rd(OFS_RES_RATE, 32'h0);
      $display("Test single shot done");
      // Continuous with errors inserted; begin must force the sequence back
      fall <= 1'b0;
      bus(1'b1, OFS_ERR_LIMIT, 32'd3);
      bus(1'b1, OFS_CHK_LIMIT, 32'd1000);
      bus(1'b1, OFS_CONFIG, 32'h9);
      bus(1'b1, OFS_CTRL, 32'h1);
      repeat (30) @(posedge clk_i);
      rd(OFS_CONFIG, 32'h8, 32'hf);
      err <= 1'b1;
      repeat (250) @(posedge clk_i);
      rd(OFS_RES_ERRORS, 32'd3);
      rd(OFS_RES_STATUS, 32'h1, 32'h1);
      err <= 1'b0;
      rd(OFS_RES_CHECKED, 32'h0, 32'h0);
      repeat (200) @(posedge clk_i);
      rd(OFS_RES_ERRORS, 32'd3);
      repeat (1000) @(posedge clk_i);
      rd(OFS_RES_CHECKED, 32'd1000);
      rd(OFS_RES_ERRORS, 32'h0);
      rd(OFS_RES_RATE, 32'h0);
      $display("Test continuous done");
      repeat (30) @(posedge clk_i);
      // Enable active low while the line holds it high: every bit is masked
      bus(1'b1, OFS_CONFIG, 32'h4);
      bus(1'b1, OFS_CTRL, 32'h1);
      repeat (60) @(posedge clk_i);
      rd(OFS_RES_CHECKED, 32'h0);
      rd(OFS_CONFIG, 32'h4, 32'hf);
      $display("Test data enable done");
      // Halt mid-run, then take the clock away
      bus(1'b1, OFS_CTRL, 32'h4);
      repeat (30) @(posedge clk_i);
      rd(OFS_RES_STATUS, 32'h1, 32'h1);
      en <= 1'b0;
      repeat (120) @(posedge clk_i);
      rd(OFS_RES_STATUS, 32'h1, 32'hf);
      $display("Test halt and idle done");
      wrap_up();
   end
endmodule // bit_error_rate_checker_tb
`default_nettype wire

// [dv/prbs_source.sv]
// Far side model: PRBS9 feedback stream with clock gating and error insertion
`timescale 1ns/1ps
`default_nettype none
module prbs_source (
   input  wire logic en_i,
   input  wire logic fall_i,
   input  wire logic err_i,
   output logic      fb_clk_o,
   output logic      fb_data_o,
   output logic      fb_den_o
);
   logic [8:0] lfsr_q = 9'h1ff;
   logic [7:0] cnt_q  = 8'h00;
   initial fb_clk_o = 1'b0;
   initial fb_data_o = 1'b0;
   assign fb_den_o = 1'b1;
   // Clock runs only when enabled; idle data keeps toggling so a stale level never looks valid
   always #16 begin
      if (en_i) begin
         fb_clk_o <= ~fb_clk_o;
         // Data moves on the edge opposite to the sampling one, keeping setup wide
         if (fb_clk_o != fall_i) begin
            lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
            cnt_q <= cnt_q + 8'h01;
            fb_data_o <= lfsr_q[8] ^ lfsr_q[4] ^ (err_i && cnt_q[3:0] == 4'h0);
         end
      end else begin
         fb_clk_o <= 1'b0;
         fb_data_o <= ~fb_data_o;
      end
   end
endmodule // prbs_source
`default_nettype wire

// [logic/ber_check_pkg.sv]
// Constants, register map and types shared by the bit error rate checker
`default_nettype none
package ber_check_pkg;
   // Register byte offsets, one 32-bit word each
   localparam logic [7:0] OFS_CTRL        = 8'h00;
   localparam logic [7:0] OFS_CONFIG      = 8'h04;
   localparam logic [7:0] OFS_CHK_LIMIT   = 8'h08;
   localparam logic [7:0] OFS_ERR_LIMIT   = 8'h0c;
   localparam logic [7:0] OFS_RES_CHECKED = 8'h10;
   localparam logic [7:0] OFS_RES_ERRORS  = 8'h14;
   localparam logic [7:0] OFS_RES_RATE    = 8'h18;
   localparam logic [7:0] OFS_RES_STATUS  = 8'h1c;
   // Command bits in the control word (write only, self clearing)
   localparam int unsigned CTRL_BEGIN_BIT   = 0;
   localparam int unsigned CTRL_TRIGGER_BIT = 1;
   localparam int unsigned CTRL_HALT_BIT    = 2;
   // Configuration fields
   localparam int unsigned CFG_SEQ_BIT  = 0;
   localparam int unsigned CFG_EDGE_BIT = 1;
   localparam int unsigned CFG_DEN_LSB  = 2;
   // Status word fields
   localparam int unsigned ST_TERM_BIT = 0;
   localparam int unsigned ST_CLK_BIT  = 1;
   localparam int unsigned ST_DATA_BIT = 2;
   localparam int unsigned ST_SYNC_BIT = 3;
   // Values after reset
   localparam logic [31:0] CHK_LIMIT_RST = 32'h0098_9680;
   localparam logic [31:0] ERR_LIMIT_RST = 32'h0000_0064;
   localparam logic        SEQ_RST       = 1'b0;
   localparam logic        EDGE_RST      = 1'b0;
   // Reference sequence and lock figures
   localparam int unsigned PRBS_LEN        = 9;
   localparam int unsigned PRBS_TAP        = 5;
   localparam logic [3:0]  LOCK_BITS       = 4'h9;
   localparam logic [4:0]  SYNC_BOUND_BITS = 5'h18;
   // Synchronised when errors times this figure stay below the checked count
   localparam logic [3:0]  SYNC_RATIO_DIV  = 4'ha;
   // Line activity window
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned ACT_WINDOW_NS  = 2000;
   localparam int unsigned ACT_WINDOW_CYC = ACT_WINDOW_NS / CLK_PERIOD_NS;
   localparam logic [5:0]  DIV_STEPS      = 6'h20;
   typedef enum {L_IDLE, L_RUN, L_DONE} link_state_t;
   typedef enum logic [1:0] {DEN_OFF, DEN_LOW, DEN_HIGH} den_mode_t;
   typedef enum logic {CMD_START, CMD_HALT} cmd_t;
endpackage
`default_nettype wire

// [logic/bit_error_rate_checker.sv]
// Bit error rate checker: Wishbone register side plus feedback link side
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bit_error_rate_checker #(
   parameter int unsigned AW = 8
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [AW-1:0] wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          fb_clk_i,
   input  wire logic          fb_data_i,
   input  wire logic          fb_den_i
);
   import ber_check_pkg::*;

   // Byte-lane merge used by the two limit words
   function automatic logic [31:0] merge_sel(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return r;
   endfunction

   // ---------------- Register side (clk_i) ----------------
   logic        ack_q;
   logic [31:0] dat_q;
   logic        seq_single_q, edge_fall_q;
   logic [1:0]  den_mode_q;
   logic [31:0] chk_lim_q, err_lim_q;
   logic        cmd_req_q, cmd_first_q;
   cmd_t        cmd_code_q;
   logic [31:0] snap_chk_q, snap_err_q;
   logic        cack_s1_q, cack_s2_q;
   logic        halted_q, wait_read_q, read_done_q;
   logic        ps_s1_q, ps_s2_q, pseen_q;
   logic [31:0] res_chk_q, res_err_q, rate_q;
   logic        res_term_q, sync_q;
   logic        div_busy_q;
   logic [5:0]  div_cnt_q;
   logic [32:0] rem_q;
   logic [31:0] div_den_q, quo_q;
   wire  [1:0]  act_q;

   // ---------------- Link side (fb_clk_i) ----------------
   logic        lrst_s1_q, lrst_s2_q;
   logic        edge_s1_q, edge_s2_q;
   logic [1:0]  den_s1_q, den_s2_q, den_s3_q, den_use_q;
   logic        fall_bit_q, fall_den_q;
   logic        creq_s1_q, creq_s2_q, creq_seen_q;
   logic        pa_s1_q, pa_s2_q;
   link_state_t lstate_q;
   logic        first_q, final_pend_q;
   logic [31:0] lim_chk_q, lim_err_q, chk_cnt_q, err_cnt_q;
   logic [PRBS_LEN-1:0] lfsr_q;
   logic [3:0]  lock_cnt_q;
   logic [4:0]  since_start_q;
   logic        data_prev_q, clk_tog_q, data_tog_q;
   logic        pub_tog_q, pub_done_q;
   logic [31:0] pub_chk_q, pub_err_q;

   // Bus decode
   wire req        = wb_cyc_i & wb_stb_i & ~ack_q;
   wire wr         = req & wb_we_i;
   wire rd         = req & ~wb_we_i;
   wire adr_ctrl   = wb_adr_i[7:0] == OFS_CTRL;
   wire adr_cfg    = wb_adr_i[7:0] == OFS_CONFIG;
   wire wr_ctrl    = wr & adr_ctrl & wb_sel_i[0];
   wire begin_cmd  = wr_ctrl & wb_dat_i[CTRL_BEGIN_BIT];
   wire trig_cmd   = wr_ctrl & wb_dat_i[CTRL_TRIGGER_BIT];
   wire halt_cmd   = wr_ctrl & wb_dat_i[CTRL_HALT_BIT];
   wire rd_checked = rd & (wb_adr_i[7:0] == OFS_RES_CHECKED);

   // Command issue; one command in flight, later ones while busy are dropped
   wire busy        = cmd_req_q != cack_s2_q;
   wire issue_halt  = halt_cmd & ~busy;
   wire issue_begin = begin_cmd & ~busy & ~halt_cmd;
   wire issue_trig  = trig_cmd & seq_single_q & ~busy & ~halt_cmd & ~begin_cmd;
   // A switch to single mode while waiting must not let the gate restart a run
   wire issue_auto  = wait_read_q & read_done_q & ~busy & ~wr_ctrl & ~seq_single_q;
   wire issue       = issue_halt | issue_begin | issue_trig | issue_auto;

   // Result arrival from the link side
   wire pub_new    = ps_s2_q != pseen_q;
   wire [35:0] err_x = {4'h0, res_err_q} * {32'h0, SYNC_RATIO_DIV};
   wire ratio_ok   = err_x < {4'h0, res_chk_q};
   wire [32:0] rem_sh = {rem_q[31:0], 1'b0};
   wire div_ge     = rem_sh >= {1'b0, div_den_q};

   wire [31:0] status_w = {28'h0, sync_q, act_q[1], act_q[0], res_term_q};
   wire [31:0] rd_word  =
      (wb_adr_i[7:0] == OFS_CONFIG)      ? {28'h0, den_mode_q, edge_fall_q, seq_single_q} :
      (wb_adr_i[7:0] == OFS_CHK_LIMIT)   ? chk_lim_q :
      (wb_adr_i[7:0] == OFS_ERR_LIMIT)   ? err_lim_q :
      (wb_adr_i[7:0] == OFS_RES_CHECKED) ? res_chk_q :
      (wb_adr_i[7:0] == OFS_RES_ERRORS)  ? res_err_q :
      (wb_adr_i[7:0] == OFS_RES_RATE)    ? rate_q :
      (wb_adr_i[7:0] == OFS_RES_STATUS)  ? status_w : 32'h0;

   // Wishbone answer one cycle after the request, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= req;
         dat_q <= rd ? rd_word : 32'h0;
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // Configuration; begin overrides a simultaneous sequence write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_single_q <= SEQ_RST;
         edge_fall_q  <= EDGE_RST;
         den_mode_q   <= DEN_OFF;
         chk_lim_q    <= CHK_LIMIT_RST;
         err_lim_q    <= ERR_LIMIT_RST;
      end else begin
         if (wr & adr_cfg & wb_sel_i[0]) begin
            seq_single_q <= wb_dat_i[CFG_SEQ_BIT];
            edge_fall_q  <= wb_dat_i[CFG_EDGE_BIT];
            den_mode_q   <= wb_dat_i[CFG_DEN_LSB +: 2];
         end
         if (issue_begin) begin
            seq_single_q <= 1'b0;
         end
         if (wr & (wb_adr_i[7:0] == OFS_CHK_LIMIT)) begin
            chk_lim_q <= merge_sel(chk_lim_q, wb_dat_i, wb_sel_i);
         end
         if (wr & (wb_adr_i[7:0] == OFS_ERR_LIMIT)) begin
            err_lim_q <= merge_sel(err_lim_q, wb_dat_i, wb_sel_i);
         end
      end
   end

   // Command toggle handshake; code and limit snapshot stay put while busy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_req_q   <= 1'b0;
         cmd_code_q  <= CMD_START;
         cmd_first_q <= 1'b0;
         snap_chk_q  <= CHK_LIMIT_RST;
         snap_err_q  <= ERR_LIMIT_RST;
         cack_s1_q   <= 1'b0;
         cack_s2_q   <= 1'b0;
      end else begin
         cack_s1_q <= creq_seen_q;
         cack_s2_q <= cack_s1_q;
         if (issue) begin
            cmd_req_q   <= ~cmd_req_q;
            cmd_code_q  <= issue_halt ? CMD_HALT : CMD_START;
            cmd_first_q <= ~issue_auto;
            snap_chk_q  <= chk_lim_q;
            snap_err_q  <= err_lim_q;
         end
      end
   end

   // Continuous restart gate: a final arms it, reading the checked count releases it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halted_q    <= 1'b0;
         wait_read_q <= 1'b0;
         read_done_q <= 1'b0;
      end else begin
         if (issue_halt) begin
            halted_q <= 1'b1;
         end else if (issue_begin | issue_trig) begin
            halted_q <= 1'b0;
         end
         if (pub_new & pub_done_q & ~seq_single_q & ~halted_q & ~issue_halt) begin
            wait_read_q <= 1'b1;
            read_done_q <= 1'b0;
         end else if (issue) begin
            wait_read_q <= 1'b0;
            read_done_q <= 1'b0;
         end else if (rd_checked) begin
            read_done_q <= 1'b1;
         end
      end
   end

   // Result capture; the link side only publishes finals after the first run
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ps_s1_q    <= 1'b0;
         ps_s2_q    <= 1'b0;
         pseen_q    <= 1'b0;
         res_chk_q  <= 32'h0;
         res_err_q  <= 32'h0;
         res_term_q <= 1'b0;
         sync_q     <= 1'b0;
      end else begin
         ps_s1_q <= pub_tog_q;
         ps_s2_q <= ps_s1_q;
         sync_q  <= act_q[0] & act_q[1] & ratio_ok;
         if (pub_new) begin
            pseen_q    <= ps_s2_q;
            res_chk_q  <= pub_chk_q;
            res_err_q  <= pub_err_q;
            res_term_q <= pub_done_q;
         end
      end
   end

   // Serial divider: rate is a 0.32 fraction of errors over checked bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_busy_q <= 1'b0;
         div_cnt_q  <= 6'h0;
         rem_q      <= 33'h0;
         div_den_q  <= 32'h0;
         quo_q      <= 32'h0;
         rate_q     <= 32'h0;
      end else if (pub_new) begin
         div_busy_q <= pub_chk_q != 32'h0;
         div_cnt_q  <= DIV_STEPS;
         rem_q      <= {1'b0, pub_err_q};
         div_den_q  <= pub_chk_q;
         quo_q      <= 32'h0;
         if (pub_chk_q == 32'h0) begin
            rate_q <= 32'h0;
         end
      end else if (div_busy_q) begin
         rem_q     <= div_ge ? rem_sh - {1'b0, div_den_q} : rem_sh;
         quo_q     <= {quo_q[30:0], div_ge};
         div_cnt_q <= div_cnt_q - 6'h1;
         if (div_cnt_q == 6'h1) begin
            div_busy_q <= 1'b0;
            rate_q     <= {quo_q[30:0], div_ge};
         end
      end
   end

   // Line activity: toggles from the link are synchronised and timed out here
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_act
         logic       a_s1_q, a_s2_q, a_s3_q, on_q;
         logic [7:0] idle_q;
         wire src = (gi == 0) ? clk_tog_q : data_tog_q;
         // Each flag has its own flop, so no variable is written by two processes
         assign act_q[gi] = on_q;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               a_s1_q <= 1'b0;
               a_s2_q <= 1'b0;
               a_s3_q <= 1'b0;
               idle_q <= 8'(ACT_WINDOW_CYC);
               on_q   <= 1'b0;
            end else begin
               a_s1_q <= src;
               a_s2_q <= a_s1_q;
               a_s3_q <= a_s2_q;
               if (a_s2_q != a_s3_q) begin
                  idle_q <= 8'h0;
                  on_q   <= 1'b1;
               end else if (idle_q != 8'(ACT_WINDOW_CYC)) begin
                  idle_q <= idle_q + 8'h1;
               end else begin
                  on_q <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ---------------- Link domain logic ----------------
   wire rx_bit  = edge_s2_q ? fall_bit_q : fb_data_i;
   wire rx_den  = edge_s2_q ? fall_den_q : fb_den_i;
   wire den_ok  = (den_use_q == DEN_OFF) | ((den_use_q == DEN_LOW) & ~rx_den) |
                  ((den_use_q == DEN_HIGH) & rx_den);
   wire new_cmd = creq_s2_q != creq_seen_q;
   wire locked  = lock_cnt_q == LOCK_BITS;
   wire take    = (lstate_q == L_RUN) & den_ok & ~new_cmd;
   wire ref_bit = lfsr_q[PRBS_LEN-1] ^ lfsr_q[PRBS_TAP-1];
   wire counted = take & locked;
   wire mism    = counted & (rx_bit != ref_bit);
   wire [31:0] chk_nx = chk_cnt_q + {31'h0, counted};
   wire [31:0] err_nx = err_cnt_q + {31'h0, mism};
   wire hit     = counted & ((chk_nx >= lim_chk_q) | (err_nx >= lim_err_q));
   wire pub_free = pub_tog_q == pa_s2_q;
   wire pub_now  = pub_free & (final_pend_q | ((lstate_q == L_RUN) & first_q));

   // Falling-edge capture for the alternative sample edge
   always_ff @(negedge fb_clk_i) begin
      fall_bit_q <= fb_data_i;
      fall_den_q <= fb_den_i;
   end

   // Synchronisers into the link domain
   always_ff @(posedge fb_clk_i) begin
      lrst_s1_q <= rst_i;
      lrst_s2_q <= lrst_s1_q;
      edge_s1_q <= edge_fall_q;
      edge_s2_q <= edge_s1_q;
      den_s1_q  <= den_mode_q;
      den_s2_q  <= den_s1_q;
      // Two-bit mode word is taken only once two samples agree, hiding a half-changed pair
      den_s3_q  <= den_s2_q;
      if (den_s2_q == den_s3_q) begin
         den_use_q <= den_s3_q;
      end
      creq_s1_q <= cmd_req_q;
      creq_s2_q <= creq_s1_q;
      pa_s1_q   <= pseen_q;
      pa_s2_q   <= pa_s1_q;
   end

   // Measurement sequencing on the feedback clock
   always_ff @(posedge fb_clk_i) begin
      if (lrst_s2_q) begin
         lstate_q     <= L_IDLE;
         creq_seen_q  <= 1'b0;
         first_q      <= 1'b0;
         final_pend_q <= 1'b0;
         lim_chk_q    <= CHK_LIMIT_RST;
         lim_err_q    <= ERR_LIMIT_RST;
      end else begin
         if (pub_now) begin
            final_pend_q <= 1'b0;
         end
         if (new_cmd) begin
            creq_seen_q <= creq_s2_q;
            if (cmd_code_q == CMD_HALT) begin
               lstate_q     <= L_DONE;
               final_pend_q <= 1'b1;
            end else begin
               lstate_q     <= L_RUN;
               first_q      <= cmd_first_q;
               final_pend_q <= 1'b0;
               lim_chk_q    <= snap_chk_q;
               lim_err_q    <= snap_err_q;
            end
         end else if (hit) begin
            lstate_q     <= L_DONE;
            final_pend_q <= 1'b1;
         end
      end
   end

   // Reference lock and counters
   always_ff @(posedge fb_clk_i) begin
      if (lrst_s2_q | (new_cmd & (cmd_code_q == CMD_START))) begin
         lfsr_q        <= '0;
         lock_cnt_q    <= 4'h0;
         since_start_q <= 5'h0;
         chk_cnt_q     <= 32'h0;
         err_cnt_q     <= 32'h0;
      end else if (take) begin
         if (since_start_q != 5'h1f) begin
            since_start_q <= since_start_q + 5'h1;
         end
         if (!locked) begin
            lfsr_q     <= {lfsr_q[PRBS_LEN-2:0], rx_bit};
            lock_cnt_q <= lock_cnt_q + 4'h1;
         end else begin
            lfsr_q    <= {lfsr_q[PRBS_LEN-2:0], ref_bit};
            chk_cnt_q <= chk_nx;
            err_cnt_q <= err_nx;
         end
      end
   end

   // Activity toggles and result publishing toward the register side
   always_ff @(posedge fb_clk_i) begin
      if (lrst_s2_q) begin
         clk_tog_q   <= 1'b0;
         data_tog_q  <= 1'b0;
         data_prev_q <= 1'b0;
         pub_tog_q   <= 1'b0;
         pub_done_q  <= 1'b0;
         pub_chk_q   <= 32'h0;
         pub_err_q   <= 32'h0;
      end else begin
         clk_tog_q   <= ~clk_tog_q;
         data_prev_q <= rx_bit;
         if (rx_bit != data_prev_q) begin
            data_tog_q <= ~data_tog_q;
         end
         if (pub_now) begin
            pub_tog_q  <= ~pub_tog_q;
            pub_done_q <= final_pend_q;
            pub_chk_q  <= chk_cnt_q;
            pub_err_q  <= err_cnt_q;
         end
      end
   end

   // ---------------- Checks ----------------
   property p_sync_needs_lines;
      @(posedge clk_i) disable iff (rst_i) sync_q |-> $past(act_q[0] & act_q[1] & ratio_ok);
   endproperty
   a_sync_needs_lines: assert property (p_sync_needs_lines) else $error("sync without active lines");

   property p_begin_forces_cont;
      @(posedge clk_i) disable iff (rst_i) issue_begin |=> !seq_single_q;
   endproperty
   a_begin_forces_cont: assert property (p_begin_forces_cont) else $error("begin kept single mode");

   property p_edge_reset;
      @(posedge clk_i) $past(rst_i) |-> !edge_fall_q && !seq_single_q;
   endproperty
   a_edge_reset: assert property (p_edge_reset) else $error("edge not rising after reset");

   property p_auto_needs_read;
      @(posedge clk_i) disable iff (rst_i) issue_auto |-> read_done_q && !seq_single_q;
   endproperty
   a_auto_needs_read: assert property (p_auto_needs_read) else $error("restart before read");

   property p_error_counts;
      @(posedge fb_clk_i) disable iff (lrst_s2_q) mism |=> err_cnt_q == $past(err_cnt_q) + 32'h1;
   endproperty
   a_error_counts: assert property (p_error_counts) else $error("mismatch not counted");

   property p_masked_not_counted;
      @(posedge fb_clk_i) disable iff (lrst_s2_q)
         (lstate_q == L_RUN && !den_ok && !new_cmd) |=> chk_cnt_q == $past(chk_cnt_q);
   endproperty
   a_masked_not_counted: assert property (p_masked_not_counted) else $error("masked bit counted");

   property p_limit_ends;
      @(posedge fb_clk_i) disable iff (lrst_s2_q) (hit && !new_cmd) |=> lstate_q == L_DONE ##1 final_pend_q || pub_tog_q != $past(pub_tog_q);
   endproperty
   a_limit_ends: assert property (p_limit_ends) else $error("limit did not end run");

   property p_lock_bound;
      @(posedge fb_clk_i) disable iff (lrst_s2_q) (since_start_q >= SYNC_BOUND_BITS) |-> locked;
   endproperty
   a_lock_bound: assert property (p_lock_bound) else $error("no lock within bound");

   c_final_seen: cover property (@(posedge clk_i) disable iff (rst_i) pub_new && pub_done_q);
   c_auto_restart: cover property (@(posedge clk_i) disable iff (rst_i) issue_auto);
   c_halt: cover property (@(posedge clk_i) disable iff (rst_i) issue_halt ##[1:40] res_term_q);
   c_synced: cover property (@(posedge clk_i) disable iff (rst_i) sync_q);
endmodule // bit_error_rate_checker
`default_nettype wire
